// >>> inc/guard_regs.vh
`ifndef GUARD_REGS_VH
`define GUARD_REGS_VH
`define ADDR_SYSTEM_FLAG_INTERRUPT_ENABLE      8'h8e
`define ADDR_PCON      8'h97
`define ADDR_CTRL      8'he1
`define ADDR_CK3       8'h41
`define CTRL_RST_VAL   8'h07
`define CK3_RST_VAL    8'h02
`define CK3_WMASK      8'hd0
`define BIT_RSTEN      7
`define BIT_NSTOP      6
`define BIT_RUN        5
`define BIT_CLR        4
`define BIT_IDLE       3
`define BIT_FLAG       0
`define BIT_FSEL       4
`define CS_HI          7
`define CS_LO          6
`define CS_RC          2'b00
`define CS_EXT         2'b01
`define CS_SYS12       2'b10
`define SYS_DIV        4'hb
`endif

// >>> design/tick_source.v
`timescale 1ns/1ps
`default_nettype none
`include "guard_regs.vh"
module tick_source (
	input  wire       clock,
	input  wire       nrst,
	input  wire       ce,
	input  wire [1:0] sel,
	input  wire       rc_tick,
	input  wire       ext_tick,
	output reg        tick
);
	reg  [3:0] div_ff;
	wire       div_end = (div_ff == `SYS_DIV);

	// System clock divided by twelve; shared with source mux
	always @(posedge clock) begin
		if (!nrst) begin
			div_ff <= 4'h0;
		end else if (ce) begin
			div_ff <= div_end ? 4'h0 : div_ff + 4'h1;
		end
	end

	always @* begin
		case (sel)
			`CS_RC:    tick = rc_tick;
			`CS_EXT:   tick = ext_tick;
			`CS_SYS12: tick = div_end;
			default:   tick = 1'b0; // Reserved code gives no time base
		endcase
	end
endmodule
`default_nettype wire

// >>> design/watchdog_timer_with_wakeup.v
`timescale 1ns/1ps
`default_nettype none
`include "guard_regs.vh"
module watchdog_timer_with_wakeup (
	input  wire       clock,
	input  wire       nrst,
	input  wire       por_n,
	input  wire       ce,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire       page_p,
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	output reg  [7:0] sfr_rdata,
	input  wire       rc_tick,
	input  wire       ext_tick,
	input  wire       cpu_idle,
	input  wire       cpu_pdown,
	input  wire       hw_non_stop_option,
	input  wire       system_flag_irq_enable,
	output wire       irq,
	output wire       wdt_reset,
	output wire       wake,
	output wire       rc_keep_on
);
	reg  [7:0] ctrl_ff;
	reg  [7:0] ck3_ff;
	reg        flag_ff;
	reg        fie_ff;
	reg  [7:0] pre_ff;
	reg  [7:0] cnt_ff;
	reg        rst_ff;
	reg  [7:0] nxt_ctrl;
	wire       base_tick;
	wire [2:0] ps;
	wire       wr_ctrl;
	wire       wr_ck3;
	wire       wr_pcon;
	wire       wr_system_flag_interrupt_enable;
	wire       run;
	wire       gate;
	wire       pre_done;
	wire       ovf;
	wire       watch_ok;

	assign ps      = ctrl_ff[2:0];
	assign wr_ctrl = sfr_wr && (sfr_addr == `ADDR_CTRL);
	assign wr_ck3  = sfr_wr && page_p && (sfr_addr == `ADDR_CK3);
	assign wr_pcon = sfr_wr && (sfr_addr == `ADDR_PCON);
	assign wr_system_flag_interrupt_enable = sfr_wr && !page_p && (sfr_addr == `ADDR_SYSTEM_FLAG_INTERRUPT_ENABLE);

	////////////////////////////////////////////////////////////////
	// Time base selection

	tick_source u_src (
		.clock    (clock),
		.nrst     (nrst),
		.ce       (ce),
		.sel      (ck3_ff[`CS_HI:`CS_LO]),
		.rc_tick  (rc_tick),
		.ext_tick (ext_tick),
		.tick     (base_tick)
	);

	////////////////////////////////////////////////////////////////
	// Control registers, reset only by power-on

	// one-time set bits; zeros need protected page
	always @* begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl[`BIT_IDLE] = sfr_wdata[`BIT_IDLE];
			nxt_ctrl[2:0] = sfr_wdata[2:0];
			if (page_p) begin
				nxt_ctrl[7:5] = sfr_wdata[7:5];
			end else begin
				nxt_ctrl[7:5] = ctrl_ff[7:5] | sfr_wdata[7:5];
			end
		end
	end

	// retained across pin, software and watchdog resets
	always @(posedge clock) begin
		if (!por_n) begin
			ctrl_ff <= `CTRL_RST_VAL;
			ck3_ff  <= `CK3_RST_VAL;
		end else if (ce) begin
			ctrl_ff <= nxt_ctrl;
			// source and event select; reserved bits stay fixed
			if (wr_ck3) begin
				ck3_ff <= (sfr_wdata & `CK3_WMASK) | `CK3_RST_VAL;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Counting gate and counter

	assign run = ctrl_ff[`BIT_RUN];
	// watch mode needs a clock that lives in power-down
	assign watch_ok = (ck3_ff[`CS_HI:`CS_LO] == `CS_RC) || (ck3_ff[`CS_HI:`CS_LO] == `CS_EXT);
	assign gate = run && (cpu_pdown ? (ctrl_ff[`BIT_NSTOP] && watch_ok)
		: (!cpu_idle || ctrl_ff[`BIT_IDLE] || hw_non_stop_option));
	// keep the RC oscillator alive in watch mode
	assign rc_keep_on = cpu_pdown && run && ctrl_ff[`BIT_NSTOP];

	// prescaler divides by two to the power ps+1
	// Terminal count is all ones in the low ps+1 bits, so code n divides by exactly 2^(n+1)
	assign pre_done = base_tick && ((pre_ff | (8'hfe << ps)) == 8'hff);

	// bit-8 overflow or bit-0 overflow as event
	assign ovf = gate && pre_done && (ck3_ff[`BIT_FSEL] ? 1'b1 : (cnt_ff == 8'hff));

	// prescaler and free-running counter; clear restarts at zero
	always @(posedge clock) begin
		if (!nrst) begin
			pre_ff <= 8'h00;
			cnt_ff <= 8'h00;
		end else if (ce) begin
			if (wr_ctrl && sfr_wdata[`BIT_CLR]) begin
				pre_ff <= 8'h00;
				cnt_ff <= 8'h00;
			end else if (gate && base_tick) begin
				// Prescaler wraps at its selected length so periods stay exact
				if (pre_done) begin
					pre_ff <= 8'h00;
					cnt_ff <= cnt_ff + 8'h01;
				end else begin
					pre_ff <= pre_ff + 8'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Flag, enables and outputs

	// hardware set wins over write-one clear
	always @(posedge clock) begin
		if (!nrst) begin
			flag_ff <= 1'b0;
			fie_ff  <= 1'b0;
			rst_ff  <= 1'b0;
		end else if (ce) begin
			if (ovf) begin
				flag_ff <= 1'b1;
			end else if (wr_pcon && sfr_wdata[`BIT_FLAG]) begin
				flag_ff <= 1'b0;
			end
			if (wr_system_flag_interrupt_enable) begin
				fie_ff <= sfr_wdata[`BIT_FLAG];
			end
			rst_ff <= ovf && ctrl_ff[`BIT_RSTEN];
		end
	end

	// level request while flag and enables hold
	assign irq = flag_ff && fie_ff && system_flag_irq_enable;
	assign wdt_reset = rst_ff;
	// wake by interrupt or reset as software chose
	assign wake = cpu_pdown && (irq || rst_ff);

	// Read mux; unmapped addresses return zero
	always @(posedge clock) begin
		if (!nrst) begin
			sfr_rdata <= 8'h00;
		end else if (ce && sfr_rd) begin
			case (sfr_addr)
				`ADDR_CTRL: sfr_rdata <= {ctrl_ff[7:5], 1'b0, ctrl_ff[3:0]};
				`ADDR_CK3:  sfr_rdata <= page_p ? ck3_ff : 8'h00;
				`ADDR_PCON: sfr_rdata <= {7'h00, flag_ff};
				`ADDR_SYSTEM_FLAG_INTERRUPT_ENABLE: sfr_rdata <= {7'h00, fie_ff};
				default:    sfr_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> test/guard_chk.sv
`timescale 1ns/1ps
`default_nettype none
module guard_chk (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       ce,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_rdata,
	input wire logic       cpu_pdown,
	input wire logic       system_flag_irq_enable,
	input wire logic       irq,
	input wire logic       wdt_reset,
	input wire logic       wake,
	input wire logic       rc_keep_on
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Alarm and wake relations
	a_wake_source: assert property (wake == (cpu_pdown && (irq || wdt_reset))) else $error("bad wake");
	a_irq_gated: assert property (irq |-> system_flag_irq_enable) else $error("irq ungated");
	a_reset_pulse: assert property (wdt_reset && ce |=> !wdt_reset) else $error("reset too long");
	a_irq_holds: assert property (irq && !sfr_wr |=> irq || !system_flag_irq_enable) else $error("irq lost");
	a_keep_on_pd: assert property (rc_keep_on |-> cpu_pdown) else $error("osc kept awake");
	// Bus side: read data holds, wdt_reset stays put while ce is low
	a_rdata_holds: assert property (!(sfr_rd && ce) |=> $stable(sfr_rdata)) else $error("rdata moved");
	a_ce_freeze: assert property (!ce |=> $stable(wdt_reset)) else $error("moved while frozen");
	a_unmapped_zero: assert property (sfr_rd && ce && !(sfr_addr inside {8'h8e, 8'h97, 8'he1, 8'h41})
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind watchdog_timer_with_wakeup guard_chk chk_u (.*);
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       clock, nrst, por_n, ce, sfr_wr, sfr_rd, page_p, rc_tick, ext_tick;
	logic       cpu_idle, cpu_pdown, hw_non_stop_option, system_flag_irq_enable;
	logic [7:0] sfr_addr, sfr_wdata;
	wire  [7:0] sfr_rdata;
	wire        irq, wdt_reset, wake, rc_keep_on;
	int         err_total, num_checks;
	watchdog_timer_with_wakeup dut_u (.clock(clock), .nrst(nrst), .por_n(por_n), .ce(ce), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .page_p(page_p), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.rc_tick(rc_tick), .ext_tick(ext_tick), .cpu_idle(cpu_idle), .cpu_pdown(cpu_pdown),
		.hw_non_stop_option(hw_non_stop_option), .system_flag_irq_enable(system_flag_irq_enable),
		.irq(irq), .wdt_reset(wdt_reset), .wake(wake), .rc_keep_on(rc_keep_on));
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	// Time bases pulse every other cycle so the counter moves fast
	always @(negedge clock) begin
		rc_tick <= ~rc_tick;
		ext_tick <= rc_tick;
	end
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
			begin
			err_total++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d, input logic p);
		sfr_addr = a;
		sfr_wdata = d;
		page_p = p;
		sfr_wr = 1;
		@(negedge clock);
		sfr_wr = 0;
		page_p = 0;
		@(negedge clock);
	endtask
	task rd(input logic [7:0] a, input logic p, input logic [7:0] exp);
		sfr_addr = a;
		page_p = p;
		sfr_rd = 1;
		@(negedge clock);
		sfr_rd = 0;
		page_p = 0;
		chk(sfr_rdata, exp);
		@(negedge clock);
	endtask
	// Bounded wait for irq (0), reset pulse (1) or wake (2)
	task wt(input int w);
		int n;
		n = 0;
		while (((w == 0) ? irq : (w == 1) ? wdt_reset : wake) !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk({7'h00, n == 300}, 8'h00);
		if (n == 300)
			end_of_test;
	endtask
	task stop_clear;
		wr(8'he1, 8'h00, 1);
		wr(8'h97, 8'h01, 0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// power-on values
	task t_por;
		rd(8'he1, 0, 8'h07);
		rd(8'h41, 1, 8'h02);
		rd(8'h97, 0, 8'h00);
		rd(8'h55, 0, 8'h00);
		$display("power-on test done");
	endtask
	task t_lock;
		wr(8'he1, 8'hf0, 0);
		rd(8'he1, 0, 8'he0);
		wr(8'he1, 8'h00, 0);
		rd(8'he1, 0, 8'he0);
		nrst = 0;
		@(negedge clock);
		nrst = 1;
		rd(8'he1, 0, 8'he0);
		wr(8'he1, 8'h00, 1);
		rd(8'he1, 0, 8'h00);
		$display("lock test done");
	endtask
	task t_flag;
		wr(8'h41, 8'h12, 1);
		rd(8'h41, 1, 8'h12);
		wr(8'h8e, 8'h01, 0);
		wr(8'he1, 8'h20, 0);
		wt(0);
		wr(8'he1, 8'h00, 1);
		system_flag_irq_enable = 0;
		#1;
		chk(irq, 0);
		system_flag_irq_enable = 1;
		wr(8'h97, 8'h00, 0);
		rd(8'h97, 0, 8'h01);
		wr(8'h97, 8'h01, 0);
		rd(8'h97, 0, 8'h00);
		chk(irq, 0);
		wr(8'he1, 8'ha0, 0);
		wt(1);
		stop_clear;
		$display("flag test done");
	endtask
	task t_idle;
		cpu_idle = 1;
		wr(8'he1, 8'h20, 0);
		ce = 0;
		repeat (60) @(negedge clock);
		ce = 1;
		repeat (60) @(negedge clock);
		rd(8'h97, 0, 8'h00);
		hw_non_stop_option = 1;
		wt(0);
		hw_non_stop_option = 0;
		stop_clear;
		wr(8'he1, 8'h28, 0);
		wt(0);
		stop_clear;
		cpu_idle = 0;
		$display("idle test done");
	endtask
	task t_watch;
		cpu_pdown = 1;
		wr(8'he1, 8'h60, 0);
		chk(rc_keep_on, 1);
		wt(2);
		stop_clear;
		wr(8'h41, 8'h92, 1);
		wr(8'he1, 8'h60, 0);
		repeat (120) @(negedge clock);
		rd(8'h97, 0, 8'h00);
		$display("watch test done");
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence: power-on reset held 12 cycles with both resets low
	initial begin
		{nrst, por_n, sfr_wr, sfr_rd, page_p, rc_tick, ext_tick, cpu_idle, cpu_pdown} = 0;
		{hw_non_stop_option, sfr_addr, sfr_wdata, err_total, num_checks} = 0;
		ce = 1;
		system_flag_irq_enable = 1;
		repeat (12) @(negedge clock);
		nrst = 1;
		por_n = 1;
		t_por;
		t_lock;
		t_flag;
		t_idle;
		t_watch;
		end_of_test;
	end
endmodule
`default_nettype wire
